// File: hdl/wlp_consts.svh
`ifndef WLP_CONSTS_SVH
`define WLP_CONSTS_SVH

// Register indices; byte address is four times the index
`define WLP_IDX_WDOG 8'h2e
`define WLP_IDX_LPCMD 8'h30
`define WLP_IDX_RELOAD 8'h31
`define WLP_ADDR_WDOG {`WLP_IDX_WDOG, 2'b00}
`define WLP_ADDR_LPCMD {`WLP_IDX_LPCMD, 2'b00}
`define WLP_ADDR_RELOAD {`WLP_IDX_RELOAD, 2'b00}

// Watchdog control register layout and reset value
`define WLP_WDOG_RESET 8'h3f
`define WLP_BIT_UPPER_ONLY 7
`define WLP_BIT_STOP_DIS 6
`define WLP_WDOG_LOW_ONES 6'h3f

// Watchdog counter loads and prescaler
`define WLP_UPPER_LOAD 7'h7f
`define WLP_LOWER_LOAD 4'hf
`define WLP_PRESCALE_LAST 8'hff
`define WLP_PERIOD_CASCADE 524288
`define WLP_PERIOD_UPPER 32768

// Low-power command bits
`define WLP_BIT_CMD_STOP 0
`define WLP_BIT_CMD_WAIT 1

// Stop wake-up timer reload reset values and divider
`define WLP_T1_RESET 8'hff
`define WLP_T2_RESET 8'h01
`define WLP_STOP_DIV_LAST 4'hf

// Reset pin timing
`define WLP_CLK_PERIOD_NS 10
`define WLP_RST_MIN_NS 2000
`define WLP_RST_MIN_CYC \
    ((`WLP_RST_MIN_NS + `WLP_CLK_PERIOD_NS - 1) / `WLP_CLK_PERIOD_NS)
`define WLP_RST_MORE_CYC 8'(`WLP_RST_MIN_CYC + 1)
`define WLP_SETTLE_CYC 12'd2047

// Start address vector locations
`define WLP_VEC_HI 16'hfffb
`define WLP_VEC_LO 16'hfffa

`endif

// File: hdl/wlp_pkg.sv
package wlp_pkg;

    // Low-power sequencing states
    typedef enum logic [1:0] {
        lp_run = 2'b00,
        lp_stop = 2'b01,
        lp_settle = 2'b10,
        lp_wait = 2'b11
    } wlp_lp_state_t;

    // Reset pin sequencing states
    typedef enum logic [1:0] {
        rs_idle = 2'b00,
        rs_held = 2'b01,
        rs_settle = 2'b10,
        rs_fetch = 2'b11
    } wlp_rst_state_t;

endpackage : wlp_pkg

// File: hdl/wlp_stop_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "wlp_consts.svh"

module wlp_stop_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic run,
    input wire logic [7:0] t1_reload,
    input wire logic [7:0] t2_reload,
    output logic t2_underflow
);

    logic [3:0] div;
    logic [7:0] t1;
    logic [7:0] t2;
    logic div_tick;
    logic t1_under;

    // ------------------------------------------------------------
    // Divide by 16 and cascaded timers
    // ------------------------------------------------------------

    // Count source for timer 1 is the oscillator over 16
    assign div_tick = run && (div == `WLP_STOP_DIV_LAST);
    assign t1_under = div_tick && (t1 == 8'h00);

    // Divider restarts with each load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 4'h0;
        end else if (load) begin
            div <= 4'h0;
        end else if (run) begin
            div <= div + 4'h1;
        end
    end

    // Timer 1 reloads on underflow and feeds timer 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1 <= `WLP_T1_RESET;
            t2 <= `WLP_T2_RESET;
        end else if (load) begin
            t1 <= t1_reload;
            t2 <= t2_reload;
        end else if (div_tick) begin
            t1 <= t1_under ? t1_reload : t1 - 8'h01;
            if (t1_under) begin
                t2 <= (t2 == 8'h00) ? t2_reload : t2 - 8'h01;
            end
        end
    end

    // One-cycle pulse when timer 2 passes zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t2_underflow <= 1'b0;
        end else begin
            t2_underflow <= t1_under && (t2 == 8'h00);
        end
    end

endmodule : wlp_stop_timer
`default_nettype wire

// File: hdl/wlp_watchdog.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "wlp_consts.svh"

// What this block does
// - Watchdog has a 7-bit upper and 4-bit lower down-counter on the clock.
// - Time-out is 524288 cycles cascaded or 32768 with upper counter only.
// - Any control write with byte lane 0 strobed loads upper with 7F and lower with F.
// - Control register reads return control bits, never counter values.
// - First control write starts counting and enables the watchdog interrupt.
// - Once running, software cannot stop it; only system reset does.
// - Watchdog underflow raises a non-maskable interrupt request.
// - Stop-disable bit blocks the stop instruction and sticks until reset.
// - Stop instruction halts oscillator and holds internal clock high.
// - Stop entry cascades and reloads timers 1 and 2, timer 1 at osc/16.
// - Oscillator restarts from stop on accepted external interrupt or reset.
// - Interrupt wake from stop holds clock high until timer 2 underflows.
// - Reset wake from stop applies a fixed settling delay first.
// - Wait instruction stops internal clock high, oscillator keeps running.
// - Wait ends on the same events as stop but resumes at once.
// - Reset pin low over 2 us, then high, fetches vector FFFB/FFFA.
module wlp_watchdog (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n,
    input wire logic ext_irq_accept,
    output logic wdog_nmi_req,
    output logic osc_enable,
    output logic clock_run,
    output logic timers_cascaded,
    output logic cpu_reset_n,
    output logic vector_fetch,
    output logic [15:0] vector_addr_hi,
    output logic [15:0] vector_addr_lo
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------

    wlp_pkg::wlp_lp_state_t lp_state;
    wlp_pkg::wlp_lp_state_t next_lp_state;
    wlp_pkg::wlp_rst_state_t rst_state;
    wlp_pkg::wlp_rst_state_t next_rst_state;

    localparam logic [7:0] wdog_reset_val = `WLP_WDOG_RESET;
    logic pin_meta;
    logic pin_sync;
    logic [7:0] pin_low_cnt;
    logic pin_long_low;
    logic [11:0] settle_cnt;
    logic from_stop;
    logic sys_reset;

    logic upper_only;
    logic stop_disable;
    logic wdog_running;
    logic [7:0] prescale;
    logic [3:0] lower_cnt;
    logic [6:0] upper_cnt;
    logic pre_tick;
    logic lower_under;
    logic upper_step;
    logic upper_under;

    logic [7:0] t1_reload;
    logic [7:0] t2_reload;
    logic stop_load;
    logic t2_underflow;

    logic setup_phase;
    logic wr_access;
    logic hit_wdog;
    logic hit_lpcmd;
    logic hit_reload;
    logic hit_any;
    logic wr_wdog;
    logic wr_lpcmd;
    logic cmd_stop;
    logic cmd_wait;
    logic [31:0] next_prdata;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------

    // Zero wait states; unmapped addresses answer with an error
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign hit_wdog = (paddr == `WLP_ADDR_WDOG);
    assign hit_lpcmd = (paddr == `WLP_ADDR_LPCMD);
    assign hit_reload = (paddr == `WLP_ADDR_RELOAD);
    assign hit_any = hit_wdog || hit_lpcmd || hit_reload;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // Any write to the control register with byte lane 0 strobed counts, whatever the data
    assign wr_wdog = wr_access && hit_wdog && pstrb[0] && !sys_reset;
    assign wr_lpcmd = wr_access && hit_lpcmd && pstrb[0] && !sys_reset;

    // Stop is refused while the stop-disable bit is set
    assign cmd_stop = wr_lpcmd && pwdata[`WLP_BIT_CMD_STOP]
        && !stop_disable;
    assign cmd_wait = wr_lpcmd && pwdata[`WLP_BIT_CMD_WAIT];

    // Read data chosen in the setup phase, held through access
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_wdog) begin
            next_prdata[7:0] = {upper_only, stop_disable,
                `WLP_WDOG_LOW_ONES};
        end else if (hit_lpcmd) begin
            next_prdata[7:0] = {4'h0, clock_run, osc_enable,
                lp_state};
        end else if (hit_reload) begin
            next_prdata[15:0] = {t2_reload, t1_reload};
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------

    // Mode bit follows writes; stop-disable only ever sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_only <= wdog_reset_val[`WLP_BIT_UPPER_ONLY];
            stop_disable <= wdog_reset_val[`WLP_BIT_STOP_DIS];
        end else if (sys_reset) begin
            upper_only <= wdog_reset_val[`WLP_BIT_UPPER_ONLY];
            stop_disable <= wdog_reset_val[`WLP_BIT_STOP_DIS];
        end else if (wr_wdog) begin
            upper_only <= pwdata[`WLP_BIT_UPPER_ONLY];
            stop_disable <= stop_disable
                || pwdata[`WLP_BIT_STOP_DIS];
        end
    end

    // Reload latches of the stop wake-up timers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_reload <= `WLP_T1_RESET;
            t2_reload <= `WLP_T2_RESET;
        end else if (sys_reset) begin
            t1_reload <= `WLP_T1_RESET;
            t2_reload <= `WLP_T2_RESET;
        end else if (wr_access && hit_reload) begin
            if (pstrb[0]) begin
                t1_reload <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                t2_reload <= pwdata[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog counters
    // ------------------------------------------------------------

    // Counters advance only while the internal clock runs
    assign pre_tick = wdog_running && clock_run
        && (prescale == `WLP_PRESCALE_LAST);
    assign lower_under = pre_tick && (lower_cnt == 4'h0);
    assign upper_step = upper_only ? pre_tick : lower_under;
    assign upper_under = upper_step && (upper_cnt == 7'h00);

    // Running flag set by the first write, cleared by reset only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_running <= 1'b0;
        end else if (sys_reset) begin
            wdog_running <= 1'b0;
        end else if (wr_wdog) begin
            wdog_running <= 1'b1;
        end
    end

    // Divide-by-256 prescaler ahead of the lower counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 8'h00;
        end else if (sys_reset || wr_wdog) begin
            prescale <= 8'h00;
        end else if (wdog_running && clock_run) begin
            prescale <= prescale + 8'h01;
        end
    end

    // Lower 4-bit down-counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_cnt <= `WLP_LOWER_LOAD;
        end else if (sys_reset || wr_wdog) begin
            lower_cnt <= `WLP_LOWER_LOAD;
        end else if (pre_tick) begin
            lower_cnt <= lower_cnt - 4'h1;
        end
    end

    // Upper 7-bit down-counter, wraps to the load value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_cnt <= `WLP_UPPER_LOAD;
        end else if (sys_reset || wr_wdog) begin
            upper_cnt <= `WLP_UPPER_LOAD;
        end else if (upper_step) begin
            upper_cnt <= upper_cnt - 7'h01;
        end
    end

    // Non-maskable request pulse on underflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_nmi_req <= 1'b0;
        end else begin
            wdog_nmi_req <= upper_under && !sys_reset;
        end
    end

    // ------------------------------------------------------------
    // Stop and wait sequencing
    // ------------------------------------------------------------

    // Timers load from their latches as stop is entered
    assign stop_load = cmd_stop && (lp_state == wlp_pkg::lp_run);

    wlp_stop_timer u_stop_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(stop_load),
        .run(lp_state == wlp_pkg::lp_settle),
        .t1_reload(t1_reload),
        .t2_reload(t2_reload),
        .t2_underflow(t2_underflow)
    );

    // Next low-power state; stop wins over wait
    always_comb begin
        next_lp_state = lp_state;
        unique case (lp_state)
            wlp_pkg::lp_run: begin
                if (cmd_stop) begin
                    next_lp_state = wlp_pkg::lp_stop;
                end else if (cmd_wait) begin
                    next_lp_state = wlp_pkg::lp_wait;
                end
            end
            wlp_pkg::lp_stop: begin
                if (ext_irq_accept) begin
                    next_lp_state = wlp_pkg::lp_settle;
                end
            end
            wlp_pkg::lp_settle: begin
                if (t2_underflow) begin
                    next_lp_state = wlp_pkg::lp_run;
                end
            end
            wlp_pkg::lp_wait: begin
                if (ext_irq_accept) begin
                    next_lp_state = wlp_pkg::lp_run;
                end
            end
        endcase
    end

    // Low-power state register; reset always returns to run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_state <= wlp_pkg::lp_run;
        end else if (sys_reset) begin
            lp_state <= wlp_pkg::lp_run;
        end else begin
            lp_state <= next_lp_state;
        end
    end

    // Clock is held high outside run; oscillator off only in stop
    assign clock_run = (lp_state == wlp_pkg::lp_run)
        && !sys_reset;
    assign osc_enable = (lp_state != wlp_pkg::lp_stop);
    assign timers_cascaded = (lp_state == wlp_pkg::lp_stop)
        || (lp_state == wlp_pkg::lp_settle);

    // ------------------------------------------------------------
    // Reset pin sequencing
    // ------------------------------------------------------------

    // Two-stage synchroniser on the reset pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= reset_pin_n;
            pin_sync <= pin_meta;
        end
    end

    // Low time counter, saturating once long enough
    assign pin_long_low = (pin_low_cnt == `WLP_RST_MORE_CYC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_low_cnt <= 8'h00;
        end else if (pin_sync) begin
            pin_low_cnt <= 8'h00;
        end else if (!pin_long_low) begin
            pin_low_cnt <= pin_low_cnt + 8'h01;
        end
    end

    // Next reset state; short pulses on the pin are ignored
    always_comb begin
        next_rst_state = rst_state;
        unique case (rst_state)
            wlp_pkg::rs_idle: begin
                if (pin_long_low) begin
                    next_rst_state = wlp_pkg::rs_held;
                end
            end
            wlp_pkg::rs_held: begin
                if (pin_sync) begin
                    next_rst_state = from_stop ? wlp_pkg::rs_settle
                        : wlp_pkg::rs_fetch;
                end
            end
            wlp_pkg::rs_settle: begin
                if (!pin_sync) begin
                    next_rst_state = wlp_pkg::rs_held;
                end else if (settle_cnt == `WLP_SETTLE_CYC) begin
                    next_rst_state = wlp_pkg::rs_fetch;
                end
            end
            wlp_pkg::rs_fetch: begin
                next_rst_state = wlp_pkg::rs_idle;
            end
        endcase
    end

    // Reset state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_state <= wlp_pkg::rs_idle;
        end else begin
            rst_state <= next_rst_state;
        end
    end

    // Remember whether reset arrived with the oscillator stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            from_stop <= 1'b0;
        end else if (rst_state == wlp_pkg::rs_idle && pin_long_low) begin
            from_stop <= (lp_state == wlp_pkg::lp_stop);
        end
    end

    // Fixed settling count after reset from stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 12'h000;
        end else if (rst_state == wlp_pkg::rs_settle) begin
            settle_cnt <= settle_cnt + 12'h001;
        end else begin
            settle_cnt <= 12'h000;
        end
    end

    // Internal system reset spans the held and settle states of the pin sequence
    assign sys_reset = (rst_state == wlp_pkg::rs_held)
        || (rst_state == wlp_pkg::rs_settle);

    // CPU reset level and vector fetch pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_reset_n <= 1'b1;
            vector_fetch <= 1'b0;
        end else begin
            cpu_reset_n <= (next_rst_state == wlp_pkg::rs_idle)
                || (next_rst_state == wlp_pkg::rs_fetch);
            vector_fetch <= (next_rst_state == wlp_pkg::rs_fetch);
        end
    end

    // Vector locations for the start address, high then low byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_addr_hi <= `WLP_VEC_HI;
            vector_addr_lo <= `WLP_VEC_LO;
        end else begin
            vector_addr_hi <= `WLP_VEC_HI;
            vector_addr_lo <= `WLP_VEC_LO;
        end
    end

endmodule : wlp_watchdog
`default_nettype wire

// File: test/wlp_watchdog_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "wlp_consts.svh"

// ----------------
// Watchdog checker
// ----------------
module wlp_watchdog_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reset_pin_n,
    input wire logic ext_irq_accept,
    input wire logic wdog_nmi_req,
    input wire logic osc_enable,
    input wire logic clock_run,
    input wire logic timers_cascaded,
    input wire logic cpu_reset_n,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr_hi,
    input wire logic [15:0] vector_addr_lo
);
    logic started;
    logic wr_ctrl;
    logic rd_ctrl;
    logic run_ok;

    // Control register accesses and core state
    assign wr_ctrl = psel && penable && pwrite && paddr == `WLP_ADDR_WDOG;
    assign rd_ctrl = psel && penable && !pwrite && paddr == `WLP_ADDR_WDOG;
    assign run_ok = cpu_reset_n && osc_enable && !timers_cascaded;

    // Set once the watchdog has been started
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started <= 1'b0;
        end else if (!cpu_reset_n) begin
            started <= 1'b0;
        end else if (wr_ctrl) begin
            started <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_nmi_one_cycle: assert property (
        wdog_nmi_req |=> !wdog_nmi_req) else $error("nmi too long");
    a_no_nmi_idle: assert property (
        !started |-> !wdog_nmi_req) else $error("nmi before start");
    a_write_reload: assert property (
        wr_ctrl |-> ##2 !wdog_nmi_req [*8]) else $error("nmi after write");
    a_ctrl_read: assert property (
        rd_ctrl |-> prdata[5:0] == 6'h3f) else $error("ctrl read bad");
    a_osc_stop: assert property (
        cpu_reset_n && !osc_enable |-> !clock_run && timers_cascaded)
        else $error("stop outputs bad");
    a_stop_wake: assert property (
        cpu_reset_n && !osc_enable && ext_irq_accept |=>
        osc_enable && timers_cascaded && !clock_run)
        else $error("stop wake bad");
    a_settle_hold: assert property (
        osc_enable && timers_cascaded |-> !clock_run)
        else $error("clock runs in settle");
    a_wait_wake: assert property (
        run_ok && !clock_run && ext_irq_accept |=> clock_run)
        else $error("wait wake late");
    a_fetch_vector: assert property (
        vector_fetch |-> cpu_reset_n && vector_addr_hi == `WLP_VEC_HI &&
        vector_addr_lo == `WLP_VEC_LO ##1 !vector_fetch)
        else $error("fetch bad");
    a_fetch_after: assert property (
        $rose(cpu_reset_n) |-> vector_fetch) else $error("no fetch");

    c_nmi: cover property (wdog_nmi_req);
    c_fetch: cover property (vector_fetch);
    c_wake: cover property ($rose(clock_run));
endmodule : wlp_watchdog_chk

bind wlp_watchdog wlp_watchdog_chk wlp_watchdog_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .ext_irq_accept(ext_irq_accept),
    .wdog_nmi_req(wdog_nmi_req), .osc_enable(osc_enable),
    .clock_run(clock_run), .timers_cascaded(timers_cascaded),
    .cpu_reset_n(cpu_reset_n), .vector_fetch(vector_fetch),
    .vector_addr_hi(vector_addr_hi), .vector_addr_lo(vector_addr_lo));

`default_nettype wire

// File: test/wlp_watchdog_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "wlp_consts.svh"

module wlp_watchdog_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic reset_pin_n, ext_irq_accept, wdog_nmi_req, osc_enable;
    logic clock_run, timers_cascaded, cpu_reset_n, vector_fetch, rd_err;
    logic [9:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd_data;
    logic [15:0] vector_addr_hi, vector_addr_lo;
    int mismatches, comparisons, cycles, n;
    logic [2:0] lp_lines;

    // Low-power outputs gathered for compares
    assign lp_lines = {osc_enable, clock_run, timers_cascaded};

    wlp_watchdog wlp_watchdog_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_pin_n(reset_pin_n), .ext_irq_accept(ext_irq_accept),
        .wdog_nmi_req(wdog_nmi_req), .osc_enable(osc_enable),
        .clock_run(clock_run), .timers_cascaded(timers_cascaded),
        .cpu_reset_n(cpu_reset_n), .vector_fetch(vector_fetch),
        .vector_addr_hi(vector_addr_hi), .vector_addr_lo(vector_addr_lo));

    // ---------------
    // Clock and tasks
    // ---------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task summarize;
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task apb(input logic wr, input logic [9:0] addr, input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input string name, input logic [9:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(name, exp, {16'h0, rd_data[15:0]});
    endtask : rd

    // Pulse the wake interrupt, count cycles until the clock runs
    task wake;
        @(posedge pclk);
        ext_irq_accept <= 1'b1;
        @(posedge pclk);
        ext_irq_accept <= 1'b0;
        #1;
        n = 1;
        while (clock_run !== 1'b1) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask : wake

    // Reset pin low for len+1 cycles, then released
    task pin(input int len);
        @(posedge pclk);
        reset_pin_n <= 1'b0;
        repeat (len) @(posedge pclk);
        #1;
        chk("in reset", {31'h0, len < 201}, {31'h0, cpu_reset_n});
        @(posedge pclk);
        reset_pin_n <= 1'b1;
        n = 0;
        if (len < 201) return;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (vector_fetch !== 1'b1);
        chk("vector hi", 32'hfffb, {16'h0, vector_addr_hi});
        chk("vector lo", 32'hfffa, {16'h0, vector_addr_lo});
    endtask : pin

    // Cuts a hung run short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 95000) begin
            mismatches++;
            summarize();
        end
    end

    // ---------
    // Scenarios
    // ---------
    initial begin
        {psel, penable, pwrite, ext_irq_accept} = 4'h0;
        {presetn, reset_pin_n, paddr, pwdata, pstrb} = {2'b01, 42'h0, 4'hf};
        {mismatches, comparisons, cycles} = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl reset", `WLP_ADDR_WDOG, 32'h3f);
        rd("reload reset", `WLP_ADDR_RELOAD, 32'h01ff);
        rd("lowpower reset", `WLP_ADDR_LPCMD, 32'hc);
        apb(1'b0, 10'h3fc, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rd_err});
        chk("ready", 32'h1, {31'h0, pready});
        pstrb <= 4'h2;
        apb(1'b1, `WLP_ADDR_RELOAD, 32'h0300);
        pstrb <= 4'hf;
        rd("reload strobe", `WLP_ADDR_RELOAD, 32'h03ff);
        apb(1'b1, `WLP_ADDR_RELOAD, 32'h0101);
        apb(1'b1, `WLP_ADDR_LPCMD, 32'h1);
        @(posedge pclk);
        #1;
        chk("stop lines", 32'h1, {29'h0, lp_lines});
        wake();
        chk("settle long", 32'h1, {31'h0, n >= 64});
        apb(1'b1, `WLP_ADDR_LPCMD, 32'h2);
        @(posedge pclk);
        #1;
        chk("wait lines", 32'h4, {29'h0, lp_lines});
        wake();
        chk("wait resume", 32'h1, n);
        apb(1'b1, `WLP_ADDR_LPCMD, 32'h1);
        pin(250);
        chk("reset settle", 32'h1, {31'h0, n >= 2048});
        apb(1'b1, `WLP_ADDR_WDOG, 32'h80);
        repeat (20000) @(posedge pclk);
        apb(1'b1, `WLP_ADDR_WDOG, 32'h80);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (wdog_nmi_req !== 1'b1);
        chk("upper period", `WLP_PERIOD_UPPER, n);
        rd("ctrl mode", `WLP_ADDR_WDOG, 32'hbf);
        apb(1'b1, `WLP_ADDR_WDOG, 32'h0);
        n = 0;
        repeat (33000) begin
            @(posedge pclk);
            #1;
            if (wdog_nmi_req === 1'b1) n++;
        end
        chk("cascade quiet", 32'h0, n);
        apb(1'b1, `WLP_ADDR_WDOG, 32'h40);
        apb(1'b1, `WLP_ADDR_WDOG, 32'h0);
        rd("ctrl sticky", `WLP_ADDR_WDOG, 32'h7f);
        apb(1'b1, `WLP_ADDR_LPCMD, 32'h1);
        @(posedge pclk);
        #1;
        chk("stop refused", 32'h1, {31'h0, osc_enable});
        pin(100);
        pin(250);
        rd("ctrl cleared", `WLP_ADDR_WDOG, 32'h3f);
        summarize();
    end
endmodule : wlp_watchdog_tb

`default_nettype wire
